// file: core/fms_cfg.svh
// Purpose: offsets, field positions and reset values of the follower scaling block
// Assumes: 32-bit AXI4-Lite words, 8-bit byte address
// Notes: one aligned word per register
`ifndef FMS_CFG_SVH
`define FMS_CFG_SVH
`define FMS_ADDR_W 8
`define FMS_OFF_MODE 8'h00
`define FMS_OFF_UREF 8'h04
`define FMS_OFF_LEAD_LINES 8'h08
`define FMS_OFF_FOL_LINES 8'h0C
`define FMS_OFF_FB_LINES 8'h10
`define FMS_OFF_MAX_RPM 8'h14
`define FMS_OFF_TRAVERSE 8'h18
`define FMS_OFF_LAY_PITCH 8'h1C
`define FMS_OFF_PROFILE 8'h20
`define FMS_OFF_LEAD_POS 8'h24
`define FMS_OFF_FOL_POS 8'h28
`define FMS_OFF_FOL_EU 8'h2C
`define FMS_OFF_STATUS 8'h30
`define FMS_UREF_MSB 23
`define FMS_DP_MSB 27
`define FMS_DP_LSB 24
`define FMS_RST_UREF 24'h000000
`define FMS_RST_DP 4'h3
`define FMS_RST_LEAD_LINES 32'h000003E8
`define FMS_RST_FOL_LINES 32'h000003E8
`define FMS_RST_FB_LINES 32'h0000003C
`define FMS_RST_MAX_RPM 32'h000007D0
`define FMS_RST_TRAVERSE 32'h00000000
`define FMS_RST_LAY_PITCH 32'h00000000
`define FMS_DIV_STEPS 6'h37
`define FMS_RESP_OKAY 2'h0
`define FMS_RESP_SLVERR 2'h2
`endif

// file: core/fms_pkg.sv
// Purpose: types shared by the follower scaling block
// Assumes: nothing beyond SystemVerilog
// Notes: mode codes are the values software writes
package fms_pkg;
  typedef enum logic [1:0] {
    FMS_DIRECT = 2'b00,
    FMS_STANDARD = 2'b01,
    FMS_LAY_ADJ = 2'b11
  } fms_mode_t;

  typedef enum logic [1:0] {
    FMS_SC_IDLE = 2'b00,
    FMS_SC_RUN = 2'b01,
    FMS_SC_DONE = 2'b10
  } fms_sc_state_t;

  typedef struct packed {
    fms_mode_t mode;
    logic [3:0] dp;
    logic [23:0] uref;
    logic [31:0] lead_lines;
    logic [31:0] fol_lines;
    logic [31:0] fb_lines;
    logic [31:0] max_rpm;
  } fms_cfg_t;
endpackage

// file: core/fms_line_counter.sv
// Purpose: signed count of encoder lines from one quadrature pair
// Assumes: phase inputs synchronous to aclk
// Notes: one count per rising edge of phase a; clear wins over a count
`timescale 1ns/1ps
module fms_line_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic clear,
  output logic [31:0] count
);
  logic a_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_q <= 1'b0;
    end else begin
      a_q <= phase_a;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h00000000;
    end else if (clear) begin
      count <= 32'h00000000;
    end else if (phase_a && !a_q) begin
      // b low on the a edge means forward travel
      count <= phase_b ? count - 32'h00000001 : count + 32'h00000001;
    end
  end
endmodule

// file: core/fms_eu_scaler.sv
// Purpose: lines times unit reference divided by lines per unit
// Assumes: start is a one-cycle pulse while idle
// Notes: restoring divide, one quotient bit a cycle; zero divisor flagged
`timescale 1ns/1ps
`include "fms_cfg.svh"
module fms_eu_scaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [31:0] lines,
  input wire logic [23:0] uref,
  input wire logic [31:0] divisor,
  output logic busy,
  output logic div_zero,
  output logic [31:0] result
);
  fms_pkg::fms_sc_state_t state_q;
  logic neg_q;
  logic [55:0] dvd_q;
  logic [32:0] rem_q;
  logic [31:0] dsr_q;
  logic [5:0] cnt_q;
  logic [31:0] mag;
  logic [32:0] rem_sh;
  logic fits;

  always_comb begin
    mag = lines[31] ? 32'h00000000 - lines : lines;
    rem_sh = {rem_q[31:0], dvd_q[55]};
    fits = rem_sh >= {1'b0, dsr_q};
  end

  assign busy = state_q != fms_pkg::FMS_SC_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fms_pkg::FMS_SC_IDLE;
      neg_q <= 1'b0;
      dvd_q <= 56'h00000000000000;
      rem_q <= 33'h000000000;
      dsr_q <= 32'h00000000;
      cnt_q <= 6'h00;
      div_zero <= 1'b0;
      result <= 32'h00000000;
    end else begin
      case (state_q)
        fms_pkg::FMS_SC_IDLE: begin
          if (start) begin
            neg_q <= lines[31];
            dvd_q <= mag * {32'h00000000, uref};
            rem_q <= 33'h000000000;
            dsr_q <= divisor;
            cnt_q <= `FMS_DIV_STEPS;
            state_q <= fms_pkg::FMS_SC_RUN;
          end
        end
        fms_pkg::FMS_SC_RUN: begin
          rem_q <= fits ? rem_sh - {1'b0, dsr_q} : rem_sh;
          dvd_q <= {dvd_q[54:0], fits};
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h00) begin
            state_q <= fms_pkg::FMS_SC_DONE;
          end
        end
        fms_pkg::FMS_SC_DONE: begin
          div_zero <= dsr_q == 32'h00000000;
          result <= neg_q ? 32'h00000000 - dvd_q[31:0] : dvd_q[31:0];
          state_q <= fms_pkg::FMS_SC_IDLE;
        end
        default: begin
          state_q <= fms_pkg::FMS_SC_IDLE;
        end
      endcase
    end
  end
endmodule

// file: core/fms_top.sv
// Purpose: follower mode selection, scaling setup and position monitors
// Assumes: AXI4-Lite master, encoder phases synchronous to aclk
// Notes: engineering-unit values are paired with the decimal position
//
// Operation
// - mode value 1 picks follower standard, value 3 picks follower lay adjusted.
// - after reset the mode holds follower standard.
// - lay adjusted takes one lay pitch off the profile length, otherwise both options match.
// - the same mode setting also offers direct mode.
// - home set clears the lead position count.
// - home set clears the follower position count.
// - the lead position count is readable as a monitor.
// - the follower position count is readable as a monitor.
// - the unit reference carries a decimal position, reset value 0 with three decimals.
// - every engineering-unit value is given with that decimal position.
// - lead lines per reel holds lead lines per reel turn or traverse, reset 1000.
// - follower lines per unit holds follower lines per reference distance, reset 1000.
// - feedback lines per rev holds feedback encoder resolution, reset 60.
// - follower max rpm holds shaft rpm at top follower speed, reset 2000.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "fms_cfg.svh"
module fms_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lead_a,
  input wire logic lead_b,
  input wire logic feedback_a,
  input wire logic feedback_b,
  input wire logic home_set,
  output logic follower_mode,
  output logic lay_adjusted,
  output logic direct_mode,
  output logic [3:0] decimal_pos,
  output logic [31:0] profile_length,
  output logic [31:0] follower_eu
);
  fms_pkg::fms_cfg_t cfg_q;
  logic [31:0] traverse_q;
  logic [31:0] lay_pitch_q;
  logic [31:0] lead_pos;
  logic [31:0] fol_pos;
  logic sc_busy;
  logic sc_div_zero;
  logic sc_start_q;

  // write channel state
  logic aw_hold_q;
  logic aw_hold_d;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic w_hold_d;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic bvalid_d;
  logic wr_hit;

  // read channel state
  logic ar_take;
  logic rvalid_d;
  logic [31:0] rd_word;
  logic rd_hit;

  function automatic logic [31:0] fms_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return m;
  endfunction

  logic [31:0] wr_word;
  logic [31:0] old_word;

  // position counters, cleared by home set
  fms_line_counter u_lead_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .phase_a(lead_a),
    .phase_b(lead_b),
    .clear(home_set),
    .count(lead_pos)
  );

  fms_line_counter u_fol_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .phase_a(feedback_a),
    .phase_b(feedback_b),
    .clear(home_set),
    .count(fol_pos)
  );

  // follower lines to engineering units, refreshed continuously
  fms_eu_scaler u_scaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(sc_start_q),
    .lines(fol_pos),
    .uref(cfg_q.uref),
    .divisor(cfg_q.fol_lines),
    .busy(sc_busy),
    .div_zero(sc_div_zero),
    .result(follower_eu)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc_start_q <= 1'b0;
    end else begin
      sc_start_q <= !sc_busy && !sc_start_q;
    end
  end

  // write address and data taken in either order
  always_comb begin
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
    aw_hold_d = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_hold_q);
    w_hold_d = w_take ? 1'b1 : (do_write ? 1'b0 : w_hold_q);
    bvalid_d = do_write ? 1'b1 : ((s_axi_bready && s_axi_bvalid) ? 1'b0 : s_axi_bvalid);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      s_axi_awready <= !aw_hold_d;
      s_axi_wready <= !w_hold_d;
      s_axi_bvalid <= bvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // old value of the addressed writable word, for byte lanes
  always_comb begin
    wr_hit = 1'b1;
    case (aw_addr_q)
      `FMS_OFF_MODE: old_word = {30'h00000000, cfg_q.mode};
      `FMS_OFF_UREF: old_word = {4'h0, cfg_q.dp, cfg_q.uref};
      `FMS_OFF_LEAD_LINES: old_word = cfg_q.lead_lines;
      `FMS_OFF_FOL_LINES: old_word = cfg_q.fol_lines;
      `FMS_OFF_FB_LINES: old_word = cfg_q.fb_lines;
      `FMS_OFF_MAX_RPM: old_word = cfg_q.max_rpm;
      `FMS_OFF_TRAVERSE: old_word = traverse_q;
      `FMS_OFF_LAY_PITCH: old_word = lay_pitch_q;
      default: begin
        old_word = 32'h00000000;
        wr_hit = 1'b0;
      end
    endcase
    wr_word = fms_merge(old_word, w_data_q, w_strb_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= `FMS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= wr_hit ? `FMS_RESP_OKAY : `FMS_RESP_SLVERR;
    end
  end

  // mode setting; code 2 is not a mode and leaves the setting unchanged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q.mode <= fms_pkg::FMS_STANDARD;
    end else if (do_write && aw_addr_q == `FMS_OFF_MODE) begin
      case (wr_word[1:0])
        2'b01: cfg_q.mode <= fms_pkg::FMS_STANDARD;
        2'b11: cfg_q.mode <= fms_pkg::FMS_LAY_ADJ;
        2'b00: cfg_q.mode <= fms_pkg::FMS_DIRECT;
        default: cfg_q.mode <= cfg_q.mode;
      endcase
    end
  end

  // unit reference value with its decimal position
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q.uref <= `FMS_RST_UREF;
      cfg_q.dp <= `FMS_RST_DP;
    end else if (do_write && aw_addr_q == `FMS_OFF_UREF) begin
      cfg_q.uref <= wr_word[`FMS_UREF_MSB:0];
      cfg_q.dp <= wr_word[`FMS_DP_MSB:`FMS_DP_LSB];
    end
  end

  // scaling settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q.lead_lines <= `FMS_RST_LEAD_LINES;
      cfg_q.fol_lines <= `FMS_RST_FOL_LINES;
      cfg_q.fb_lines <= `FMS_RST_FB_LINES;
      cfg_q.max_rpm <= `FMS_RST_MAX_RPM;
    end else if (do_write) begin
      case (aw_addr_q)
        `FMS_OFF_LEAD_LINES: cfg_q.lead_lines <= wr_word;
        `FMS_OFF_FOL_LINES: cfg_q.fol_lines <= wr_word;
        `FMS_OFF_FB_LINES: cfg_q.fb_lines <= wr_word;
        `FMS_OFF_MAX_RPM: cfg_q.max_rpm <= wr_word;
        default: begin
        end
      endcase
    end
  end

  // traverse and lay pitch in follower lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      traverse_q <= `FMS_RST_TRAVERSE;
      lay_pitch_q <= `FMS_RST_LAY_PITCH;
    end else if (do_write) begin
      if (aw_addr_q == `FMS_OFF_TRAVERSE) begin
        traverse_q <= wr_word;
      end
      if (aw_addr_q == `FMS_OFF_LAY_PITCH) begin
        lay_pitch_q <= wr_word;
      end
    end
  end

  // profile length; lay adjusted drops one lay pitch, floored at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      profile_length <= 32'h00000000;
    end else if (cfg_q.mode == fms_pkg::FMS_LAY_ADJ) begin
      profile_length <= (traverse_q > lay_pitch_q) ? traverse_q - lay_pitch_q : 32'h00000000;
    end else begin
      profile_length <= traverse_q;
    end
  end

  // mode flags and decimal position for the motion logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      follower_mode <= 1'b0;
      lay_adjusted <= 1'b0;
      direct_mode <= 1'b0;
      decimal_pos <= 4'h0;
    end else begin
      follower_mode <= cfg_q.mode != fms_pkg::FMS_DIRECT;
      lay_adjusted <= cfg_q.mode == fms_pkg::FMS_LAY_ADJ;
      direct_mode <= cfg_q.mode == fms_pkg::FMS_DIRECT;
      decimal_pos <= cfg_q.dp;
    end
  end

  // read channel: one read at a time, answer one cycle after address
  always_comb begin
    ar_take = s_axi_arvalid && s_axi_arready;
    rvalid_d = ar_take ? 1'b1 : ((s_axi_rready && s_axi_rvalid) ? 1'b0 : s_axi_rvalid);
  end

  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `FMS_OFF_MODE: rd_word = {30'h00000000, cfg_q.mode};
      `FMS_OFF_UREF: rd_word = {4'h0, cfg_q.dp, cfg_q.uref};
      `FMS_OFF_LEAD_LINES: rd_word = cfg_q.lead_lines;
      `FMS_OFF_FOL_LINES: rd_word = cfg_q.fol_lines;
      `FMS_OFF_FB_LINES: rd_word = cfg_q.fb_lines;
      `FMS_OFF_MAX_RPM: rd_word = cfg_q.max_rpm;
      `FMS_OFF_TRAVERSE: rd_word = traverse_q;
      `FMS_OFF_LAY_PITCH: rd_word = lay_pitch_q;
      `FMS_OFF_PROFILE: rd_word = profile_length;
      `FMS_OFF_LEAD_POS: rd_word = lead_pos;
      `FMS_OFF_FOL_POS: rd_word = fol_pos;
      `FMS_OFF_FOL_EU: rd_word = follower_eu;
      `FMS_OFF_STATUS: rd_word = {24'h000000, cfg_q.dp, sc_div_zero, lay_adjusted, direct_mode,
                                  follower_mode};
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FMS_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `FMS_RESP_OKAY : `FMS_RESP_SLVERR;
    end
  end

endmodule

// file: tb/fms_top_props.sv
// Purpose: port checks for the follower scaling block
// Assumes: bound to fms_top, single clock domain
// Notes: flags may follow a write by one or two edges
`timescale 1ns/1ps
module fms_top_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic home_set,
  input wire logic follower_mode,
  input wire logic lay_adjusted,
  input wire logic direct_mode,
  input wire logic [3:0] decimal_pos,
  input wire logic [31:0] follower_eu
);
  logic [1:0] rel_q;
  logic [7:0] home_q;
  // edges since reset release, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) rel_q <= 2'h0;
    else if (rel_q != 2'h3) rel_q <= rel_q + 2'h1;
  end
  // edges with home set held
  always_ff @(posedge aclk) begin
    if (!aresetn || !home_set) home_q <= 8'h00;
    else if (home_q != 8'hFF) home_q <= home_q + 8'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_mode;
    rel_q == 2'h2 |-> follower_mode && !lay_adjusted && !direct_mode && decimal_pos == 4'h3;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("bad mode after reset");
  property p_lay_follower;
    lay_adjusted |-> follower_mode && !direct_mode;
  endproperty
  a_lay_follower: assert property (p_lay_follower) else $error("lay option outside follower");
  property p_direct_excl;
    direct_mode |-> !follower_mode && !lay_adjusted;
  endproperty
  a_direct_excl: assert property (p_direct_excl) else $error("direct mode with follower");
  property p_flags_follow_write;
    rel_q == 2'h3 && ($changed(decimal_pos) || $changed(follower_mode) || $changed(direct_mode))
      |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_flags_follow_write: assert property (p_flags_follow_write) else $error("flags moved without write");
  property p_home_eu;
    home_q == 8'h82 |-> follower_eu == 32'h00000000;
  endproperty
  a_home_eu: assert property (p_home_eu) else $error("units not zero under home set");
  property p_write_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response late");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data late");
  property p_read_single;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_read_single: assert property (p_read_single) else $error("read data repeated");
endmodule
bind fms_top fms_top_props u_fms_top_props (.*);

// file: tb/fms_enc_model.sv
// Purpose: quadrature encoder for lead or feedback shaft
// Assumes: start is one cycle; reverse held while busy
// Notes: four clocks per line, phases change just after an edge
`timescale 1ns/1ps
module fms_enc_model (
  input wire logic aclk,
  input wire logic start,
  input wire logic reverse,
  input wire logic [15:0] lines,
  output logic phase_a,
  output logic phase_b,
  output logic busy
);
  logic [17:0] left_q = 18'h00000;
  logic [1:0] ph_q = 2'h0;
  always_ff @(posedge aclk) begin
    if (start) begin
      left_q <= {lines, 2'h0};
    end else if (left_q != 18'h00000) begin
      left_q <= left_q - 18'h00001;
      ph_q <= ph_q + 2'h1;
    end
  end
  // b lags a going forward, leads in reverse
  assign phase_a = reverse ? ph_q[1] : ph_q[0] ^ ph_q[1];
  assign phase_b = reverse ? ph_q[0] ^ ph_q[1] : ph_q[1];
  assign busy = left_q != 18'h00000;
endmodule

// file: tb/fms_top_tb.sv
// Purpose: register, mode and position tests of the follower scaling block
// Assumes: AXI4-Lite master tasks, two encoder models
// Notes: each write waits three edges so flags settle
`timescale 1ns/1ps
`include "fms_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module fms_top_tb;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] ERR = 2'h2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, profile_length, follower_eu;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic home_set = 1'b0, enc_go = 1'b0, enc_rev = 1'b0;
  logic [15:0] lead_n = 16'h0000, fb_n = 16'h0000;
  logic lead_a, lead_b, feedback_a, feedback_b, lead_busy, fb_busy;
  logic follower_mode, lay_adjusted, direct_mode;
  logic [3:0] decimal_pos;
  logic [31:0] mcode [4] = '{32'h3, 32'h0, 32'h2, 32'h1};
  logic [31:0] mstat [4] = '{32'h35, 32'h32, 32'h32, 32'h31};
  logic [2:0] mflag [4] = '{3'b110, 3'b001, 3'b001, 3'b100};
  int num_errors = 0;
  int tests_run = 0;
  always #2 aclk = ~aclk;
  fms_top u_fms_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .lead_a(lead_a), .lead_b(lead_b), .feedback_a(feedback_a), .feedback_b(feedback_b),
    .home_set(home_set), .follower_mode(follower_mode), .lay_adjusted(lay_adjusted), .direct_mode(direct_mode),
    .decimal_pos(decimal_pos), .profile_length(profile_length), .follower_eu(follower_eu));
  fms_enc_model u_lead_enc (.aclk(aclk), .start(enc_go), .reverse(enc_rev), .lines(lead_n), .phase_a(lead_a),
    .phase_b(lead_b), .busy(lead_busy));
  fms_enc_model u_fb_enc (.aclk(aclk), .start(enc_go), .reverse(enc_rev), .lines(fb_n), .phase_a(feedback_a),
    .phase_b(feedback_b), .busy(fb_busy));
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid === 1'b1;
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
    repeat (3) @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      r = s_axi_rvalid === 1'b1;
    end
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask
  // both shafts move together, then the scaler settles
  task automatic move(input logic rev, input logic [15:0] ln, input logic [15:0] fn);
    @(posedge aclk);
    enc_rev <= rev;
    lead_n <= ln;
    fb_n <= fn;
    enc_go <= 1'b1;
    @(posedge aclk);
    enc_go <= 1'b0;
    @(posedge aclk);
    while (lead_busy || fb_busy) @(posedge aclk);
    repeat (140) @(posedge aclk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK({follower_mode, lay_adjusted, direct_mode, decimal_pos}, 7'h43)
    axi_rd(`FMS_OFF_MODE, 32'h00000001, OK);
    axi_rd(`FMS_OFF_UREF, 32'h03000000, OK);
    axi_rd(`FMS_OFF_LEAD_LINES, 32'h000003E8, OK);
    axi_rd(`FMS_OFF_FOL_LINES, 32'h000003E8, OK);
    axi_rd(`FMS_OFF_FB_LINES, 32'h0000003C, OK);
    axi_rd(`FMS_OFF_MAX_RPM, 32'h000007D0, OK);
    for (int i = 0; i < 4; i++) begin
      axi_wr(`FMS_OFF_MODE, mcode[i], OK);
      axi_rd(`FMS_OFF_STATUS, mstat[i], OK);
      `CHK({follower_mode, lay_adjusted, direct_mode}, mflag[i])
    end
    axi_wr(`FMS_OFF_TRAVERSE, 32'h000001F4, OK);
    axi_wr(`FMS_OFF_LAY_PITCH, 32'h00000028, OK);
    axi_rd(`FMS_OFF_PROFILE, 32'h000001F4, OK);
    axi_wr(`FMS_OFF_MODE, 32'h00000003, OK);
    axi_rd(`FMS_OFF_PROFILE, 32'h000001CC, OK);
    `CHK(profile_length, 32'h000001CC)
    axi_wr(`FMS_OFF_LAY_PITCH, 32'h00000258, OK);
    axi_rd(`FMS_OFF_PROFILE, 32'h00000000, OK);
    move(1'b0, 16'h0019, 16'h000A);
    move(1'b1, 16'h0000, 16'h0003);
    axi_rd(`FMS_OFF_LEAD_POS, 32'h00000019, OK);
    axi_rd(`FMS_OFF_FOL_POS, 32'h00000007, OK);
    axi_wr(`FMS_OFF_UREF, 32'h020005DC, OK);
    repeat (130) @(posedge aclk);
    `CHK(decimal_pos, 4'h2)
    axi_rd(`FMS_OFF_FOL_EU, 32'h0000000A, OK);
    move(1'b1, 16'h0000, 16'h0014);
    axi_rd(`FMS_OFF_FOL_POS, 32'hFFFFFFF3, OK);
    `CHK(follower_eu, 32'hFFFFFFED)
    home_set <= 1'b1;
    repeat (140) @(posedge aclk);
    axi_rd(`FMS_OFF_LEAD_POS, 32'h00000000, OK);
    axi_rd(`FMS_OFF_FOL_POS, 32'h00000000, OK);
    `CHK(follower_eu, 32'h00000000)
    home_set <= 1'b0;
    axi_wr(`FMS_OFF_PROFILE, 32'h00000001, ERR);
    axi_wr(8'h3C, 32'h00000001, ERR);
    axi_rd(8'h3C, 32'h00000000, ERR);
    for (int i = 0; i < 4; i++) begin
      axi_wr(`FMS_OFF_LEAD_LINES + 8'(4 * i), 32'h00001230 + 32'(i), OK);
      axi_rd(`FMS_OFF_LEAD_LINES + 8'(4 * i), 32'h00001230 + 32'(i), OK);
    end
    wrap_up();
  end
endmodule
